/* File: cce_defs.vh */
// Purpose: Shared constants of the compare/clear execution unit.
// Assumes: Included by its bare name from every design file.
// Notes:   Definitions only.
`ifndef CCE_DEFS_VH
`define CCE_DEFS_VH

// ----------------------------------------------------------------
// Register port offsets
// ----------------------------------------------------------------
`define CCE_OFF_ACC    3'h0
`define CCE_OFF_XLO    3'h1
`define CCE_OFF_XHI    3'h2
`define CCE_OFF_FLAGS  3'h3
`define CCE_OFF_PC     3'h4
`define CCE_OFF_SP     3'h5
`define CCE_OFF_STAT   3'h6

// ----------------------------------------------------------------
// Flags register bit positions and reset values
// ----------------------------------------------------------------
`define CCE_FV         7
`define CCE_FH         4
`define CCE_FI         3
`define CCE_FN         2
`define CCE_FZ         1
`define CCE_FC         0
`define CCE_FLAGS_ONES 8'h60
`define CCE_FLAGS_RST  8'h68
`define CCE_PC_RST     16'h0000
`define CCE_SP_RST     16'h00ff

// ----------------------------------------------------------------
// Opcodes of the group
// ----------------------------------------------------------------
`define CCE_PREBYTE    8'h9e
`define CCE_OP_CBQ_DIR 8'h31
`define CCE_OP_CBQ_ACC 8'h41
`define CCE_OP_CBQ_XRG 8'h51
`define CCE_OP_CBQ_OPI 8'h61
`define CCE_OP_CBQ_IPI 8'h71
`define CCE_OP_CARRY0  8'h98
`define CCE_OP_UNMASK  8'h9a
`define CCE_OP_CLR_DIR 8'h3f
`define CCE_OP_CLR_ACC 8'h4f
`define CCE_OP_CLR_XLO 8'h5f
`define CCE_OP_CLR_XHI 8'h8c
`define CCE_OP_CLR_IX1 8'h6f
`define CCE_OP_CLR_IX  8'h7f
`define CCE_OP_CMP_IMM 8'ha1
`define CCE_OP_CMP_DIR 8'hb1
`define CCE_OP_CMP_EXT 8'hc1
`define CCE_OP_CMP_IX2 8'hd1
`define CCE_OP_CMP_IX1 8'he1
`define CCE_OP_CMP_IX  8'hf1
`define CCE_OP_INV_DIR 8'h33
`define CCE_OP_INV_ACC 8'h43
`define CCE_OP_INV_XLO 8'h53
`define CCE_OP_INV_IX1 8'h63
`define CCE_OP_INV_IX  8'h73
`define CCE_OP_IPT_IMM 8'h65
`define CCE_OP_IPT_DIR 8'h75

`endif

/* File: cce_sub_flags.v */
// Purpose: Flag outcome of a two's complement subtraction lhs - rhs.
// Assumes: Purely combinational; WIDTH is 8 or 16 in this unit.
// Notes:   Carry is the borrow out of the most significant bit.
`timescale 1ns/1ps
`include "cce_defs.vh"

module cce_sub_flags #(
  parameter WIDTH = 8
) (
  // Operands
  input  wire [WIDTH-1:0] lhs,
  input  wire [WIDTH-1:0] rhs,
  // Flag outcome
  output wire             ovf,
  output wire             neg,
  output wire             zero,
  output wire             borrow
);

  wire [WIDTH-1:0] diff;
  wire             l7;
  wire             m7;
  wire             r7;

  // Difference and the sign bits that the flag equations use.
  assign diff   = lhs - rhs;
  assign l7     = lhs[WIDTH-1];
  assign m7     = rhs[WIDTH-1];
  assign r7     = diff[WIDTH-1];

  // Signed overflow, sign, zero test and unsigned borrow.
  assign ovf    = (l7 & ~m7 & ~r7) | (~l7 & m7 & r7);
  assign neg    = r7;
  assign zero   = (diff == {WIDTH{1'b0}});
  assign borrow = (~l7 & m7) | (m7 & r7) | (r7 & ~l7);

endmodule

/* File: cce_exec.v */
// Purpose: Execution unit for compare-branch, carry clear, unmask, clear,
//          accumulator compare, invert and index-pair compare.
// Assumes: Instructions arrive fully fetched; operands come from memory or literal bytes.
// Notes:   Architectural registers are visible on the register port.
// Behaviour
// - Direct/literal compare-branch: equal gives PC+3+offset.
// - Post-increment PC+2+offset; stack-offset PC+4+offset.
// - X-literal variant compares low index byte.
// - Compare-branch never changes any flag.
// - Post-increment reads at index pair, then increments.
// - Offset variant adds unsigned byte, still increments.
// - Carry clear zeroes carry, keeps others.
// - Unmask drops the mask at cycle end.
// - After unmasking a set mask, next instruction executes first.
// - Clear zeroes target; V,N clear, Z set.
// - Accumulator compare leaves accumulator and memory intact.
// - Accumulator compare overflow on signed subtraction overflow.
// - Compare negative is bit 7; zero on zero.
// - Compare carry is the unsigned borrow.
// - Invert replaces target with its bitwise inverse.
// - Invert clears V, sets C, updates N,Z.
// - Index-pair compare subtracts big-endian word, no writes.
// - Index-pair compare flags from 16-bit difference.
`timescale 1ns/1ps
`include "cce_defs.vh"

module cce_exec (
  // Clock, reset and clock enable
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        clk_en,
  // Instruction issue
  input  wire        ins_valid,
  input  wire        ins_prebyte,
  input  wire [7:0]  ins_opcode,
  input  wire [7:0]  ins_opnd1,
  input  wire [7:0]  ins_opnd2,
  output wire        ins_ready,
  output wire        op_done,
  output wire        op_bad,
  // Interrupt boundary
  input  wire        irq_req,
  output wire        irq_take,
  // Operand memory
  output wire [15:0] mem_addr,
  output wire        mem_rd,
  output wire        mem_wr,
  output wire [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  // Register port
  input  wire [2:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata
);

  // ----------------------------------------------------------------
  // Local codes
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_RD   = 4'b0010;
  localparam [3:0] S_RD2  = 4'b0100;
  localparam [3:0] S_EX   = 4'b1000;

  localparam [2:0] K_NONE = 3'd0;
  localparam [2:0] K_CBQ  = 3'd1;
  localparam [2:0] K_CLC  = 3'd2;
  localparam [2:0] K_CLI  = 3'd3;
  localparam [2:0] K_CLR  = 3'd4;
  localparam [2:0] K_CMP  = 3'd5;
  localparam [2:0] K_INV  = 3'd6;
  localparam [2:0] K_IPT  = 3'd7;

  localparam [1:0] T_MEM  = 2'd0;
  localparam [1:0] T_ACC  = 2'd1;
  localparam [1:0] T_XLO  = 2'd2;
  localparam [1:0] T_XHI  = 2'd3;

  localparam [2:0] M_IMM  = 3'd0;
  localparam [2:0] M_DIR  = 3'd1;
  localparam [2:0] M_EXT  = 3'd2;
  localparam [2:0] M_IX2  = 3'd3;
  localparam [2:0] M_IX1  = 3'd4;
  localparam [2:0] M_IX   = 3'd5;
  localparam [2:0] M_SP2  = 3'd6;
  localparam [2:0] M_SP1  = 3'd7;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Mode of a read-modify-write form from its opcode high nibble.
  function [2:0] rmw_mode;
    input [3:0] nib;
    begin
      case (nib)
        4'h6:    rmw_mode = M_IX1;
        4'h7:    rmw_mode = M_IX;
        default: rmw_mode = M_DIR;
      endcase
    end
  endfunction

  // Effective address of a memory operand.
  function [15:0] eff_addr;
    input [2:0]  mode;
    input [7:0]  o1;
    input [7:0]  o2;
    input [15:0] hx;
    input [15:0] sp;
    begin
      case (mode)
        M_EXT:   eff_addr = {o1, o2};
        M_IX2:   eff_addr = hx + {o1, o2};
        M_IX1:   eff_addr = hx + {8'h00, o1};
        M_IX:    eff_addr = hx;
        M_SP2:   eff_addr = sp + {o1, o2};
        M_SP1:   eff_addr = sp + {8'h00, o1};
        default: eff_addr = {8'h00, o1};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [3:0]  state_reg;
  reg [7:0]  acc_reg;
  reg [15:0] hx_reg;
  reg [15:0] sp_reg;
  reg [15:0] pc_reg;
  reg [7:0]  flags_reg;
  reg        inhibit_reg;
  reg [2:0]  kind_reg;
  reg [1:0]  tgt_reg;
  reg [15:0] ea_reg;
  reg [2:0]  len_reg;
  reg [7:0]  rel_reg;
  reg        inc_reg;
  reg        wide_reg;
  reg        xcmp_reg;
  reg        rdm_reg;
  reg [15:0] imm_reg;
  reg [7:0]  hi_reg;
  reg        ready_reg;
  reg        done_reg;
  reg        bad_reg;
  reg        take_reg;
  reg [15:0] maddr_reg;
  reg        mrd_reg;
  reg        mwr_reg;
  reg [7:0]  mwdata_reg;
  reg [15:0] rdata_reg;

  // Outputs come straight from flops.
  assign ins_ready = ready_reg;
  assign op_done   = done_reg;
  assign op_bad    = bad_reg;
  assign irq_take  = take_reg;
  assign mem_addr  = maddr_reg;
  assign mem_rd    = mrd_reg;
  assign mem_wr    = mwr_reg;
  assign mem_wdata = mwdata_reg;
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  reg [2:0] d_kind;
  reg [1:0] d_tgt;
  reg [2:0] d_mode;
  reg [2:0] d_len;
  reg [7:0] d_rel;
  reg       d_inc;
  reg       d_xcmp;
  reg       d_wide;
  reg       d_rd;

  // Opcode table; the prebyte turns offset-indexed forms into stack forms.
  always @* begin
    d_kind = K_NONE;
    d_tgt  = T_MEM;
    d_mode = M_IMM;
    d_len  = 3'd1;
    d_rel  = ins_opnd2;
    d_inc  = 1'b0;
    d_xcmp = 1'b0;
    d_wide = 1'b0;
    case (ins_opcode)
      `CCE_OP_CBQ_DIR: begin
        d_kind = K_CBQ;
        d_mode = M_DIR;
        d_len  = 3'd3;
      end
      `CCE_OP_CBQ_ACC: begin
        d_kind = K_CBQ;
        d_len  = 3'd3;
      end
      `CCE_OP_CBQ_XRG: begin
        d_kind = K_CBQ;
        d_len  = 3'd3;
        d_xcmp = 1'b1;
      end
      `CCE_OP_CBQ_OPI: begin
        d_kind = K_CBQ;
        d_mode = M_IX1;
        d_len  = 3'd3;
        d_inc  = 1'b1;
      end
      `CCE_OP_CBQ_IPI: begin
        d_kind = K_CBQ;
        d_mode = M_IX;
        d_len  = 3'd2;
        d_rel  = ins_opnd1;
        d_inc  = 1'b1;
      end
      `CCE_OP_CARRY0: d_kind = K_CLC;
      `CCE_OP_UNMASK: d_kind = K_CLI;
      `CCE_OP_CLR_DIR, `CCE_OP_CLR_IX1, `CCE_OP_CLR_IX: begin
        d_kind = K_CLR;
        d_mode = rmw_mode(ins_opcode[7:4]);
        d_len  = (ins_opcode[7:4] == 4'h7) ? 3'd1 : 3'd2;
      end
      `CCE_OP_CLR_ACC: begin
        d_kind = K_CLR;
        d_tgt  = T_ACC;
      end
      `CCE_OP_CLR_XLO: begin
        d_kind = K_CLR;
        d_tgt  = T_XLO;
      end
      `CCE_OP_CLR_XHI: begin
        d_kind = K_CLR;
        d_tgt  = T_XHI;
      end
      `CCE_OP_CMP_IMM, `CCE_OP_CMP_DIR, `CCE_OP_CMP_EXT,
      `CCE_OP_CMP_IX2, `CCE_OP_CMP_IX1, `CCE_OP_CMP_IX: begin
        d_kind = K_CMP;
        case (ins_opcode[7:4])
          4'ha:    d_len = 3'd2;
          4'hb:    begin d_mode = M_DIR; d_len = 3'd2; end
          4'hc:    begin d_mode = M_EXT; d_len = 3'd3; end
          4'hd:    begin d_mode = M_IX2; d_len = 3'd3; end
          4'he:    begin d_mode = M_IX1; d_len = 3'd2; end
          default: d_mode = M_IX;
        endcase
      end
      `CCE_OP_INV_DIR, `CCE_OP_INV_IX1, `CCE_OP_INV_IX: begin
        d_kind = K_INV;
        d_mode = rmw_mode(ins_opcode[7:4]);
        d_len  = (ins_opcode[7:4] == 4'h7) ? 3'd1 : 3'd2;
      end
      `CCE_OP_INV_ACC: begin
        d_kind = K_INV;
        d_tgt  = T_ACC;
      end
      `CCE_OP_INV_XLO: begin
        d_kind = K_INV;
        d_tgt  = T_XLO;
      end
      `CCE_OP_IPT_IMM: begin
        d_kind = K_IPT;
        d_len  = 3'd3;
      end
      `CCE_OP_IPT_DIR: begin
        d_kind = K_IPT;
        d_mode = M_DIR;
        d_len  = 3'd2;
        d_wide = 1'b1;
      end
      default: d_kind = K_NONE;
    endcase
    // Only the five stack-addressed forms accept the prebyte.
    if (ins_prebyte) begin
      if (ins_opcode == `CCE_OP_CBQ_OPI || ins_opcode == `CCE_OP_CLR_IX1 ||
          ins_opcode == `CCE_OP_CMP_IX2 || ins_opcode == `CCE_OP_CMP_IX1 ||
          ins_opcode == `CCE_OP_INV_IX1) begin
        d_len  = d_len + 3'd1;
        d_inc  = 1'b0;
        d_mode = (d_mode == M_IX2) ? M_SP2 : M_SP1;
      end else begin
        d_kind = K_NONE;
      end
    end
    // Clear needs no read; register targets and literals never read.
    d_rd = (d_kind == K_CBQ || d_kind == K_CMP || d_kind == K_INV ||
            d_kind == K_IPT) && d_mode != M_IMM && d_tgt == T_MEM;
  end

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  wire        accept;
  wire        irq_go;
  wire [7:0]  opnd8;
  wire [15:0] opnd16;
  wire [7:0]  cbq_lhs;
  wire        cbq_hit;
  wire [15:0] pc_seq;
  wire [15:0] pc_br;
  wire [7:0]  un_src;
  wire [7:0]  un_res;
  wire        c8_v;
  wire        c8_n;
  wire        c8_z;
  wire        c8_c;
  wire        c16_v;
  wire        c16_n;
  wire        c16_z;
  wire        c16_c;

  // Handshake and interrupt boundary; an accepted instruction wins.
  assign accept  = state_reg[0] & ins_valid & ready_reg;
  assign irq_go  = state_reg[0] & irq_req & ~accept &
                   ~flags_reg[`CCE_FI] & ~inhibit_reg;

  // Operand selection: memory data or literal bytes.
  assign opnd8   = rdm_reg ? mem_rdata : imm_reg[15:8];
  assign opnd16  = rdm_reg ? {hi_reg, mem_rdata} : imm_reg;

  // Compare-branch equality and target program counter.
  assign cbq_lhs = xcmp_reg ? hx_reg[7:0] : acc_reg;
  assign cbq_hit = (cbq_lhs == opnd8);
  assign pc_seq  = pc_reg + {13'h0000, len_reg};
  assign pc_br   = pc_seq + {{8{rel_reg[7]}}, rel_reg};

  // Clear and invert share one unary result path.
  assign un_src  = (tgt_reg == T_ACC) ? acc_reg :
                   (tgt_reg == T_XLO) ? hx_reg[7:0] :
                   (tgt_reg == T_XHI) ? hx_reg[15:8] : mem_rdata;
  assign un_res  = (kind_reg == K_INV) ? ~un_src : 8'h00;

  // Accumulator compare flags.
  cce_sub_flags #(
    .WIDTH (8)
  ) u_cmp8 (
    .lhs    (acc_reg),
    .rhs    (opnd8),
    .ovf    (c8_v),
    .neg    (c8_n),
    .zero   (c8_z),
    .borrow (c8_c)
  );

  // Index-pair compare flags.
  cce_sub_flags #(
    .WIDTH (16)
  ) u_cmp16 (
    .lhs    (hx_reg),
    .rhs    (opnd16),
    .ovf    (c16_v),
    .neg    (c16_n),
    .zero   (c16_z),
    .borrow (c16_c)
  );

  // ----------------------------------------------------------------
  // Sequencer and architectural registers
  // ----------------------------------------------------------------
  // All state freezes while clk_en is low; reset acts regardless.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg   <= S_IDLE;
      acc_reg     <= 8'h00;
      hx_reg      <= 16'h0000;
      sp_reg      <= `CCE_SP_RST;
      pc_reg      <= `CCE_PC_RST;
      flags_reg   <= `CCE_FLAGS_RST;
      inhibit_reg <= 1'b0;
      kind_reg    <= K_NONE;
      tgt_reg     <= T_MEM;
      ea_reg      <= 16'h0000;
      len_reg     <= 3'd1;
      rel_reg     <= 8'h00;
      inc_reg     <= 1'b0;
      wide_reg    <= 1'b0;
      xcmp_reg    <= 1'b0;
      rdm_reg     <= 1'b0;
      imm_reg     <= 16'h0000;
      hi_reg      <= 8'h00;
      ready_reg   <= 1'b1;
      done_reg    <= 1'b0;
      bad_reg     <= 1'b0;
      take_reg    <= 1'b0;
      maddr_reg   <= 16'h0000;
      mrd_reg     <= 1'b0;
      mwr_reg     <= 1'b0;
      mwdata_reg  <= 8'h00;
      rdata_reg   <= 16'h0000;
    end else if (clk_en) begin
      mrd_reg   <= 1'b0;
      mwr_reg   <= 1'b0;
      done_reg  <= 1'b0;
      bad_reg   <= 1'b0;
      take_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
      // Register port read, answered in the following cycle.
      if (reg_rd) begin
        case (reg_addr)
          `CCE_OFF_ACC:   rdata_reg <= {8'h00, acc_reg};
          `CCE_OFF_XLO:   rdata_reg <= {8'h00, hx_reg[7:0]};
          `CCE_OFF_XHI:   rdata_reg <= {8'h00, hx_reg[15:8]};
          `CCE_OFF_FLAGS: rdata_reg <= {8'h00, flags_reg};
          `CCE_OFF_PC:    rdata_reg <= pc_reg;
          `CCE_OFF_SP:    rdata_reg <= sp_reg;
          `CCE_OFF_STAT:  rdata_reg <= {14'h0000, inhibit_reg, ~state_reg[0]};
          default:        rdata_reg <= 16'h0000;
        endcase
      end
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            kind_reg <= d_kind;
            tgt_reg  <= d_tgt;
            ea_reg   <= eff_addr(d_mode, ins_opnd1, ins_opnd2, hx_reg, sp_reg);
            len_reg  <= d_len;
            rel_reg  <= d_rel;
            inc_reg  <= d_inc;
            wide_reg <= d_wide;
            xcmp_reg <= d_xcmp;
            rdm_reg  <= d_rd;
            imm_reg  <= {ins_opnd1, ins_opnd2};
            if (d_kind == K_NONE) begin
              bad_reg <= 1'b1;
            end else if (d_rd) begin
              mrd_reg   <= 1'b1;
              maddr_reg <= eff_addr(d_mode, ins_opnd1, ins_opnd2, hx_reg, sp_reg);
              ready_reg <= 1'b0;
              state_reg <= S_RD;
            end else begin
              ready_reg <= 1'b0;
              state_reg <= S_EX;
            end
          end else if (irq_go) begin
            take_reg              <= 1'b1;
            flags_reg[`CCE_FI]    <= 1'b1;
          end else if (reg_wr) begin
            case (reg_addr)
              `CCE_OFF_ACC:   acc_reg        <= reg_wdata[7:0];
              `CCE_OFF_XLO:   hx_reg[7:0]    <= reg_wdata[7:0];
              `CCE_OFF_XHI:   hx_reg[15:8]   <= reg_wdata[7:0];
              `CCE_OFF_FLAGS: flags_reg      <= reg_wdata[7:0] | `CCE_FLAGS_ONES;
              `CCE_OFF_PC:    pc_reg         <= reg_wdata;
              `CCE_OFF_SP:    sp_reg         <= reg_wdata;
              default:        acc_reg        <= acc_reg;
            endcase
          end
        end
        S_RD: begin
          // A big-endian word needs a second read of the next byte.
          if (wide_reg) begin
            mrd_reg   <= 1'b1;
            maddr_reg <= ea_reg + 16'h0001;
            state_reg <= S_RD2;
          end else begin
            state_reg <= S_EX;
          end
        end
        S_RD2: begin
          hi_reg    <= mem_rdata;
          state_reg <= S_EX;
        end
        S_EX: begin
          pc_reg      <= pc_seq;
          inhibit_reg <= 1'b0;
          done_reg    <= 1'b1;
          ready_reg   <= 1'b1;
          state_reg   <= S_IDLE;
          case (kind_reg)
            K_CBQ: begin
              // Flags untouched whether or not the branch is taken.
              if (cbq_hit) begin
                pc_reg <= pc_br;
              end
              if (inc_reg) begin
                hx_reg <= hx_reg + 16'h0001;
              end
            end
            K_CLC: flags_reg[`CCE_FC] <= 1'b0;
            K_CLI: begin
              flags_reg[`CCE_FI] <= 1'b0;
              inhibit_reg        <= flags_reg[`CCE_FI];
            end
            K_CLR, K_INV: begin
              case (tgt_reg)
                T_ACC: acc_reg      <= un_res;
                T_XLO: hx_reg[7:0]  <= un_res;
                T_XHI: hx_reg[15:8] <= un_res;
                default: begin
                  mwr_reg    <= 1'b1;
                  maddr_reg  <= ea_reg;
                  mwdata_reg <= un_res;
                end
              endcase
              flags_reg[`CCE_FV] <= 1'b0;
              flags_reg[`CCE_FN] <= un_res[7];
              flags_reg[`CCE_FZ] <= (un_res == 8'h00);
              if (kind_reg == K_INV) begin
                flags_reg[`CCE_FC] <= 1'b1;
              end
            end
            K_CMP: begin
              // Only flags change; accumulator and memory stay put.
              flags_reg[`CCE_FV] <= c8_v;
              flags_reg[`CCE_FN] <= c8_n;
              flags_reg[`CCE_FZ] <= c8_z;
              flags_reg[`CCE_FC] <= c8_c;
            end
            K_IPT: begin
              flags_reg[`CCE_FV] <= c16_v;
              flags_reg[`CCE_FN] <= c16_n;
              flags_reg[`CCE_FZ] <= c16_z;
              flags_reg[`CCE_FC] <= c16_c;
            end
            default: pc_reg <= pc_seq;
          endcase
        end
        default: begin
          ready_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: cce_exec_sva.sv */
// Purpose: Port checks on the execution unit.
// Assumes: One clock domain, rst_b active low.
// Notes:   Sees only top-level ports.
`timescale 1ns/1ps
module cce_exec_sva (
  // Watched ports
  input wire        core_clk,
  input wire        rst_b,
  input wire        ins_valid,
  input wire        ins_ready,
  input wire        op_done,
  input wire        irq_req,
  input wire        irq_take,
  input wire        mem_rd,
  input wire        mem_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // An accepted group instruction makes the unit busy.
  sequence s_acc;
    ins_valid && ins_ready;
  endsequence
  sequence s_start;
    s_acc ##1 !ins_ready;
  endsequence
  a_done_bound: assert property (s_start |-> ##[1:3] op_done)
    else $error("instruction did not complete in time");
  a_done_ready: assert property (op_done |-> ins_ready)
    else $error("busy in completion cycle");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("completion pulse too long");
  a_mem_excl: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  a_wr_done: assert property (mem_wr |-> op_done)
    else $error("memory write outside completion");
  a_take_idle: assert property (irq_take |-> $past(irq_req) && $past(ins_ready)
    && !$past(ins_valid && ins_ready))
    else $error("interrupt taken while busy");
  a_take_once: assert property (irq_take |=> !irq_take)
    else $error("interrupt taken twice");
  a_rdata_idle: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data without read");
endmodule
bind cce_exec cce_exec_sva u_sva (.core_clk, .rst_b, .ins_valid, .ins_ready, .op_done,
  .irq_req, .irq_take, .mem_rd, .mem_wr, .reg_rd, .reg_rdata);

/* File: cce_exec_tb.sv */
// Purpose: Self-checking bench for the execution unit.
// Assumes: Memory is modelled here with one-cycle reads.
// Notes:   clk_en is held high throughout.
`timescale 1ns/1ps
module cce_exec_tb;
  logic        core_clk, rst_b, ins_valid, ins_prebyte, ins_ready, op_done;
  logic        irq_req, irq_take, mem_rd, mem_wr, reg_wr, reg_rd, op_bad;
  logic [7:0]  ins_opcode, ins_opnd1, ins_opnd2, mem_rdata, mem_wdata;
  logic [15:0] mem_addr, reg_wdata, reg_rdata;
  logic [2:0]  reg_addr;
  logic [7:0]  mem [0:65535];
  int          errors, comparisons;
  cce_exec dut (.core_clk, .rst_b, .clk_en(1'b1), .ins_valid, .ins_prebyte,
    .ins_opcode, .ins_opnd1, .ins_opnd2, .ins_ready, .op_done, .op_bad,
    .irq_req, .irq_take, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // ------------------------------------------------------------
  // Clock, memory and bus tasks
  // ------------------------------------------------------------
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Read data is valid only in the cycle after a read; it toggles otherwise.
  always @(posedge core_clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
  task automatic chk(input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input [2:0] a, input [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rc(input [2:0] a, input [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask
  // Issues one instruction and returns in its completion cycle.
  task automatic run(input [7:0] op, a, b, input pb = 0);
    int n;
    @(posedge core_clk);
    ins_valid <= 1; ins_opcode <= op; ins_opnd1 <= a; ins_opnd2 <= b; ins_prebyte <= pb;
    @(posedge core_clk);
    ins_valid <= 0;
    for (n = 0; n < 8 && op_done !== 1; n++) @(negedge core_clk);
    if (n == 8) begin errors++; give_verdict(); end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_compare_branch_equal();
    rc(3, 16'h0068); rc(5, 16'h00ff); rc(7, 16'h0000);
    wr(3, 8'h97); wr(0, 8'h5a); wr(4, 16'h1000); mem[16'h0040] = 8'h5a;
    run(8'h31, 8'h40, 8'hf0); rc(4, 16'h0ff3);
    rc(3, 16'h00f7);
    run(8'h41, 8'h5b, 8'h10); rc(4, 16'h0ff6);
    wr(1, 8'h22); run(8'h51, 8'h22, 8'h10); rc(4, 16'h1009);
    rc(3, 16'h00f7);
  endtask
  task automatic t_post();
    wr(2, 8'h01); wr(1, 8'hff); wr(4, 16'h2000);
    mem[16'h01ff] = 8'h5a; mem[16'h0210] = 8'h00; mem[16'h0101] = 8'h5a;
    run(8'h71, 8'h7f, 8'h00); rc(4, 16'h2081);
    rc(2, 16'h0002);
    run(8'h61, 8'h10, 8'h80); rc(4, 16'h2084);
    rc(1, 16'h0001);
    run(8'h61, 8'h02, 8'h80, 1); rc(4, 16'h2008);
  endtask
  task automatic t_irq();
    int n;
    wr(3, 8'hff); run(8'h98, 0, 0); rc(3, 16'h00fe);
    @(posedge core_clk);
    irq_req <= 1;
    run(8'h9a, 0, 0); chk(reg_rdata, 0); rc(3, 16'h00f6);
    repeat (3) begin @(negedge core_clk); chk(irq_take, 0); end
    run(8'h98, 0, 0);
    for (n = 0; n < 4 && irq_take !== 1; n++) @(negedge core_clk);
    chk(irq_take, 1);
    @(posedge core_clk);
    irq_req <= 0;
    rc(3, 16'h00fe);
  endtask
  task automatic t_clr();
    logic [7:0] op3 [3] = '{8'h4f, 8'h5f, 8'h8c};
    wr(3, 8'h95); wr(0, 8'h77); wr(1, 8'h77); wr(2, 8'h77);
    for (int i = 0; i < 3; i++) begin run(op3[i], 0, 0); rc(i[2:0], 0); end
    rc(3, 16'h0073);
    mem[16'h0030] = 8'h77; run(8'h3f, 8'h30, 0);
    @(negedge core_clk); chk({8'h00, mem[16'h0030]}, 0);
    mem[16'h0000] = 8'h77; run(8'h7f, 0, 0);
    @(negedge core_clk); chk(mem[16'h0000], 0);
  endtask
  task automatic t_cmp();
    logic [7:0] av [4] = '{8'h80, 8'h01, 8'h05, 8'h03};
    logic [7:0] mv [4] = '{8'h01, 8'h80, 8'h05, 8'h05};
    logic [7:0] r, f;
    for (int i = 0; i < 4; i++) begin
      wr(3, 8'h70); wr(0, av[i]); run(8'ha1, mv[i], 0);
      r = av[i] - mv[i];
      f = {(av[i][7] & ~mv[i][7] & ~r[7]) | (~av[i][7] & mv[i][7] & r[7]), 7'h70};
      f[2:0] = {r[7], r == 0, mv[i] > av[i]};
      rc(3, f);
      rc(0, av[i]);
    end
    mem[16'h1234] = 8'h03; run(8'hc1, 8'h12, 8'h34); rc(3, 16'h0072);
    mem[16'h0100] = 8'h04; run(8'hd1, 8'h00, 8'h01, 1); rc(3, 16'h0075);
  endtask
  task automatic t_inv();
    wr(0, 8'hff); run(8'h43, 0, 0); rc(0, 0);
    rc(3, 16'h0073);
    mem[16'h0031] = 8'h0f; run(8'h33, 8'h31, 0);
    @(negedge core_clk); chk(mem[16'h0031], 8'hf0);
    rc(3, 16'h0075);
    run(8'h53, 0, 0); rc(1, 16'h00ff);
  endtask
  task automatic t_index_pair_test();
    wr(2, 8'h80); wr(1, 8'h00); wr(3, 8'h60);
    run(8'h65, 8'h00, 8'h01); rc(3, 16'h00e0);
    rc(2, 16'h0080);
    mem[16'h0050] = 8'h80; mem[16'h0051] = 8'h00;
    run(8'h75, 8'h50, 0); rc(3, 16'h0062);
  endtask
  // A prebyte on a non-stack form is refused and leaves the program counter alone.
  task automatic t_bad();
    wr(4, 16'h3000);
    @(posedge core_clk);
    ins_valid <= 1; ins_opcode <= 8'h31; ins_prebyte <= 1;
    @(posedge core_clk);
    ins_valid <= 0; ins_prebyte <= 0;
    @(negedge core_clk); chk(op_bad, 1);
    rc(4, 16'h3000);
  endtask
  initial begin
    {rst_b, ins_valid, ins_prebyte, irq_req, reg_wr, reg_rd} = 0;
    {ins_opcode, ins_opnd1, ins_opnd2, reg_addr, reg_wdata} = 0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1;
    t_compare_branch_equal(); t_post(); t_irq(); t_clr(); t_cmp(); t_inv(); t_index_pair_test(); t_bad();
    give_verdict();
  end
endmodule
